// *** pkg/rcfs_consts.vh ***
// constants for the rate-change fir sequencer
`ifndef RCFS_CONSTS_VH
`define RCFS_CONSTS_VH
// sequencer states
`define RCFS_ST_IDLE 2'h0
`define RCFS_ST_CALC 2'h1
`define RCFS_ST_EMIT 2'h2
// reset values
`define RCFS_PHASE_RST 8'h00
`define RCFS_ACC_RST 40'h0000000000
`endif

// *** rtl/rcfs_skid_buffer.v ***
// two-entry valid/ready buffer
`timescale 1ns/1ns
`default_nettype none
module rcfs_skid_buffer #(
  parameter W = 16
) (
  input wire clk,
  input wire resetn,
  input wire inValid,
  output wire inReady,
  input wire [W-1:0] inData,
  output wire outValid,
  input wire outReady,
  output wire [W-1:0] outData
);
  reg [W-1:0] mem_q [0:1];
  reg rdPtr_q;
  reg wrPtr_q;
  reg [1:0] count_q;
  wire push;
  wire pop;
  // honest full and empty from the occupancy count
  assign inReady = (count_q != 2'h2);
  assign outValid = (count_q != 2'h0);
  assign outData = mem_q[rdPtr_q];
  assign push = inValid & inReady;
  assign pop = outValid & outReady;
  // pointer and count update
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdPtr_q <= 1'b0;
      wrPtr_q <= 1'b0;
      count_q <= 2'h0;
    end else begin
      if (push) wrPtr_q <= ~wrPtr_q;
      if (pop) rdPtr_q <= ~rdPtr_q;
      if (push && !pop) count_q <= count_q + 2'h1;
      else if (pop && !push) count_q <= count_q - 2'h1;
    end
  end
  // storage, no reset needed
  always @(posedge clk) begin
    if (push) mem_q[wrPtr_q] <= inData;
  end
endmodule
`default_nettype wire

// *** rtl/rcfs_sequencer.v ***
// decimating/interpolating fir sequencer with datapath
// Notes
// - the coefficient store is read asynchronously: coefData must answer the
//   coefAddr presented in the same cycle.
// - interpRatio must not exceed the tap count; ratios of zero act as one.
// - decimRatio, interpRatio and linearPhase are levels that stay fixed
//   while the sequencer runs; change them only under reset.
// - the sample store has no reset, so the first outputs after reset mix in
//   whatever the store held until the taps have filled.
// - padding zeros cost one idle cycle each but no store space: they only move the
//   start phase that picks the first coefficient.
// - the address register holds on the last tap so that it never points
//   past the coefficients in use.
// - outputs pass a two-entry buffer and a final register, so a stalled
//   receiver holds the sequencer in its emit state without losing a word.
`timescale 1ns/1ns
`default_nettype none
`include "rcfs_consts.vh"
module rcfs_sequencer #(
  parameter DW = 16,
  parameter CW = 16,
  parameter AW = 40,
  parameter NTAPS = 16,
  parameter LOGN = 4
) (
  input wire clk,
  input wire resetn,
  input wire [7:0] decimRatio,
  input wire [7:0] interpRatio,
  input wire linearPhase,
  input wire sampleValid,
  output reg sampleReady,
  input wire [DW-1:0] sampleData,
  output reg [LOGN-1:0] coefAddr,
  input wire [CW-1:0] coefData,
  output reg outValid,
  input wire outReady,
  output reg [AW-1:0] outData
);
  // ******************************************************
  // signals
  // ******************************************************
  // tap count at counter width
  localparam [LOGN:0] NTAPS_W = NTAPS;
  // distance from the newest to the oldest sample in the store
  localparam [LOGN-1:0] LAST_TAP = NTAPS_W[LOGN-1:0] -
    {{(LOGN-1){1'b0}}, 1'b1};
  reg [DW-1:0] store_q [0:NTAPS-1];
  reg [LOGN-1:0] wrAddr_q;
  reg [1:0] state_q;
  reg [7:0] phase_q;
  reg [7:0] toGo_q;
  reg [LOGN-1:0] dataIdx_q;
  reg [LOGN:0] coefIdx_q;
  reg [LOGN:0] tapCnt_q;
  reg [AW-1:0] acc_q;
  reg bufValid_q;
  reg [AW-1:0] bufData_q;
  wire bufReady;
  wire obValid;
  wire [AW-1:0] obData;
  wire [7:0] qRatio;
  wire [7:0] pRatio;
  wire [8:0] phaseSum;
  wire [8:0] phaseWrap;
  wire [LOGN:0] halfTaps;
  wire [LOGN-1:0] newest;
  wire [LOGN-1:0] mirror;
  wire [DW:0] pairSum;
  wire signed [DW+CW:0] prod;
  wire take;
  wire zeroStep;
  wire lastTap;
  // ratios of zero act as one
  assign qRatio = (interpRatio == 8'h00) ? 8'h01 : interpRatio;
  assign pRatio = (decimRatio == 8'h00) ? 8'h01 : decimRatio;
  assign halfTaps = linearPhase ? (NTAPS_W >> 1) : NTAPS_W;
  assign newest = wrAddr_q - {{(LOGN-1){1'b0}}, 1'b1};
  // ******************************************************
  // input acceptance and zero accounting
  // ******************************************************
  // phase + 1 marks one padding zero; at q it wraps to a true sample slot
  assign phaseSum = {1'b0, phase_q} + 9'h001;
  assign phaseWrap = (phaseSum >= {1'b0, qRatio}) ? 9'h000 : phaseSum;
  // a slot is a zero if the next phase is non-zero
  assign zeroStep = (state_q == `RCFS_ST_IDLE) && (toGo_q != 8'h00) &&
    (phaseWrap != 9'h000);
  assign take = (state_q == `RCFS_ST_IDLE) && (toGo_q != 8'h00) &&
    (phaseWrap == 9'h000) && sampleValid && sampleReady;
  // write port of the cyclic store, only in idle (no computation)
  always @(posedge clk) begin
    if (take) store_q[wrAddr_q] <= sampleData;
  end
  // ******************************************************
  // datapath: unchanged multiply-accumulate
  // ******************************************************
  // oldest sample plus the tap index pairs with newest minus the index
  assign mirror = newest - LAST_TAP + dataIdx_q;
  assign pairSum = linearPhase ?
    {store_q[newest - dataIdx_q][DW-1], store_q[newest - dataIdx_q]} +
    {store_q[mirror][DW-1], store_q[mirror]} :
    {store_q[newest - dataIdx_q][DW-1], store_q[newest - dataIdx_q]};
  assign prod = $signed(pairSum) * $signed(coefData);
  // last tap when the next coefficient would leave the used range;
  // one spare bit keeps the sum from wrapping
  assign lastTap = ({1'b0, coefIdx_q} + {1'b0, qRatio[LOGN:0]}) >=
    {1'b0, halfTaps};
  // ******************************************************
  // control sequencer
  // ******************************************************
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= `RCFS_ST_IDLE;
      phase_q <= `RCFS_PHASE_RST;
      toGo_q <= 8'h01;
      wrAddr_q <= {LOGN{1'b0}};
      dataIdx_q <= {LOGN{1'b0}};
      coefIdx_q <= {(LOGN+1){1'b0}};
      tapCnt_q <= {(LOGN+1){1'b0}};
      acc_q <= `RCFS_ACC_RST;
      coefAddr <= {LOGN{1'b0}};
      sampleReady <= 1'b0;
      bufValid_q <= 1'b0;
      bufData_q <= `RCFS_ACC_RST;
    end else begin
      sampleReady <= 1'b0;
      case (state_q)
        `RCFS_ST_IDLE: begin
          if (toGo_q == 8'h00) begin
            // first coefficient is the start phase of the newest point
            coefIdx_q <= {1'b0, phase_q[LOGN-1:0]};
            coefAddr <= phase_q[LOGN-1:0];
            dataIdx_q <= {LOGN{1'b0}};
            acc_q <= `RCFS_ACC_RST;
            state_q <= `RCFS_ST_CALC;
          end else if (zeroStep) begin
            // apparent zero: no store write, start moves on
            phase_q <= phaseWrap[7:0];
            toGo_q <= toGo_q - 8'h01;
          end else if (take) begin
            wrAddr_q <= wrAddr_q + {{(LOGN-1){1'b0}}, 1'b1};
            phase_q <= 8'h00;
            toGo_q <= toGo_q - 8'h01;
          end else begin
            sampleReady <= 1'b1;
          end
        end
        `RCFS_ST_CALC: begin
          acc_q <= acc_q + {{(AW-DW-CW-1){prod[DW+CW]}}, prod};
          dataIdx_q <= dataIdx_q + {{(LOGN-1){1'b0}}, 1'b1};
          coefIdx_q <= coefIdx_q + qRatio[LOGN:0];
          // prefetch the next coefficient, hold on the last tap
          if (lastTap) begin
            state_q <= `RCFS_ST_EMIT;
          end else begin
            coefAddr <= coefIdx_q[LOGN-1:0] + qRatio[LOGN-1:0];
          end
        end
        `RCFS_ST_EMIT: begin
          if (!bufValid_q) begin
            bufValid_q <= 1'b1;
            bufData_q <= acc_q;
            toGo_q <= pRatio;
            state_q <= `RCFS_ST_IDLE;
          end
        end
        default: state_q <= `RCFS_ST_IDLE;
      endcase
      if (bufValid_q && bufReady) bufValid_q <= 1'b0;
    end
  end
  // ******************************************************
  // output buffer and registered output
  // ******************************************************
  rcfs_skid_buffer #(
    .W(AW)
  ) u_buf (
    .clk(clk),
    .resetn(resetn),
    .inValid(bufValid_q),
    .inReady(bufReady),
    .inData(bufData_q),
    .outValid(obValid),
    .outReady(~outValid | outReady),
    .outData(obData)
  );
  // output stage straight from flops
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      outValid <= 1'b0;
      outData <= `RCFS_ACC_RST;
    end else if (!outValid || outReady) begin
      outValid <= obValid;
      outData <= obData;
    end
  end
endmodule
`default_nettype wire

// *** dv/rcfs_seq_assertions.sv ***
// port checker for the rate-change fir sequencer
`timescale 1ns/1ns
`default_nettype none
module rcfs_seq_assertions #(
  parameter AW = 40,
  parameter NTAPS = 16,
  parameter LOGN = 4
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] decimRatio,
  input wire logic [7:0] interpRatio,
  input wire logic linearPhase,
  input wire logic sampleValid,
  input wire logic sampleReady,
  input wire logic [LOGN-1:0] coefAddr,
  input wire logic outValid,
  input wire logic outReady,
  input wire logic [AW-1:0] outData
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // a sample is taken; plain means no rate change
  wire logic take = sampleReady && sampleValid;
  wire logic plain = decimRatio <= 8'h01 && interpRatio <= 8'h01;
  a_valid_held: assert property (
    outValid && !outReady |=> outValid) else $error("output dropped");
  a_data_held: assert property (
    outValid && !outReady |=> $stable(outData)) else $error("data moved");
  a_rst_clear: assert property (
    $rose(resetn) |-> !outValid && !sampleReady && coefAddr == '0)
    else $error("not clear after reset");
  a_take_busy: assert property (
    take && plain |=> !sampleReady [*3]) else $error("taken while busy");
  a_out_soon: assert property (
    take && plain |-> ##[1:60] outValid) else $error("no output");
  a_lin_half: assert property (
    linearPhase |-> coefAddr < NTAPS / 2) else $error("upper half used");
  a_lin_step: assert property (
    linearPhase && $changed(coefAddr) |->
    coefAddr == LOGN'($past(coefAddr) + 1) || coefAddr == '0)
    else $error("linear step wrong");
  a_coef_step: assert property (
    !linearPhase && interpRatio != 8'h00 && $changed(coefAddr) |->
    coefAddr == LOGN'($past(coefAddr) + interpRatio)
    || coefAddr < interpRatio) else $error("coefficient step wrong");
endmodule
bind rcfs_sequencer rcfs_seq_assertions #(.AW(AW), .NTAPS(NTAPS),
  .LOGN(LOGN)) chk (.clk(clk), .resetn(resetn), .decimRatio(decimRatio),
  .interpRatio(interpRatio), .linearPhase(linearPhase),
  .sampleValid(sampleValid), .sampleReady(sampleReady),
  .coefAddr(coefAddr), .outValid(outValid), .outReady(outReady),
  .outData(outData));
`default_nettype wire

// *** dv/rcfs_coef_rom.sv ***
// coefficient store model answering in the same cycle
`timescale 1ns/1ns
`default_nettype none
module rcfs_coef_rom #(
  parameter CW = 16,
  parameter LOGN = 4
) (
  input wire logic [LOGN-1:0] addr,
  output logic [CW-1:0] data
);
  // coefficient n sits at address n-1 and holds n
  assign data = CW'(addr) + 1'b1;
endmodule
`default_nettype wire

// *** dv/tb_top.sv ***
// self-checking bench for the rate-change fir sequencer
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] decimRatio = 8'h01;
  logic [7:0] interpRatio = 8'h01;
  logic linearPhase = 1'b0;
  logic sampleValid = 1'b0;
  logic outReady = 1'b0;
  logic [15:0] sampleData = 16'h0000;
  logic sampleReady, outValid;
  logic [1:0] coefAddr;
  logic [15:0] coefData;
  logic [39:0] outData;
  logic [15:0] hist [$];
  int fails = 0;
  int comparisons = 0;
  // 250 mhz clock
  always #2 clk = ~clk;
  rcfs_sequencer #(.NTAPS(4), .LOGN(2)) dut (.clk(clk), .resetn(resetn),
    .decimRatio(decimRatio), .interpRatio(interpRatio),
    .linearPhase(linearPhase),
    .sampleValid(sampleValid), .sampleReady(sampleReady),
    .sampleData(sampleData), .coefAddr(coefAddr), .coefData(coefData),
    .outValid(outValid), .outReady(outReady), .outData(outData));
  rcfs_coef_rom #(.LOGN(2)) rom (.addr(coefAddr), .data(coefData));
  task test_done;
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task check40(input logic [39:0] got, input logic [39:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t out %h exp %h", $time, got, exp);
    end
  endtask
  // expected output from the sample history, newest first
  // q is the interpolation ratio, ph the start phase of the newest point
  function automatic logic [39:0] fir(input bit lp, input int q,
    input int ph);
    logic [39:0] y = 40'h0;
    for (int j = 0; j < 4; j++) begin
      if (!lp && ph + j * q < 4) y += 40'(ph + 1 + j * q) * hist[j];
      else if (lp && j < 2) y += 40'(j + 1) * (hist[j] + hist[3-j]);
    end
    return y;
  endfunction
  // offer one sample and hold it until the edge that takes it
  task send(input logic [15:0] x);
    int i;
    logic rdy;
    sampleValid = 1'b1;
    sampleData = x;
    for (i = 0; i < 300; i++) begin
      rdy = sampleReady;
      @(posedge clk);
      #1;
      if (rdy === 1'b1) break;
    end
    if (i == 300) begin
      fails++;
      test_done;
    end
    sampleValid = 1'b0;
    sampleData = ~x;
  endtask
  // wait for an output under stall, compare, then accept it
  task recv(input logic [39:0] exp, input bit chk);
    int i;
    for (i = 0; i < 300 && outValid !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    if (i == 300) begin
      fails++;
      test_done;
    end
    repeat (2) @(posedge clk);
    #1;
    if (chk) check40(outData, exp);
    outReady = 1'b1;
    @(posedge clk);
    #1;
    outReady = 1'b0;
  endtask
  // reset, then stream twelve samples through the buffer
  task run(input logic [7:0] p, input logic lp);
    resetn = 1'b0;
    decimRatio = p;
    interpRatio = 8'h01;
    linearPhase = lp;
    repeat (3) @(posedge clk);
    #1;
    resetn = 1'b1;
    hist = {};
    for (int k = 0; k < 12; k++) begin
      send(16'(k * 3 + 1));
      hist.push_front(16'(k * 3 + 1));
      if (k % p == 0) recv(fir(lp, 1, 0), k >= 3);
    end
  endtask
  // interpolate by two: a zero slot output, then a true sample output
  task run_interp;
    resetn = 1'b0;
    decimRatio = 8'h01;
    interpRatio = 8'h02;
    linearPhase = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    resetn = 1'b1;
    hist = {};
    for (int k = 0; k < 8; k++) begin
      recv(fir(1'b0, 2, 1), k >= 2);
      send(16'(k * 5 + 2));
      hist.push_front(16'(k * 5 + 2));
      recv(fir(1'b0, 2, 0), k >= 1);
    end
  endtask
  initial begin
    run(8'h01, 1'b0);
    run(8'h01, 1'b1);
    run(8'h02, 1'b0);
    run_interp;
    test_done;
  end
endmodule
`default_nettype wire
